/* File: hw/dc_breaker_channel_control.sv */
// Notes on behaviour
// - Breaker reports off, on, or tripped.
// - Power-on state is off, on, or retained last state.
// - Default lock decides if breaker starts locked.
// - Dimmed type follows its pulse-width counter duty.
// - Ramped type starts at set duty, full on after one second.
// - Pairs 1/2 and 11/12 both bridge type form an H-bridge.
// - Ramped bridge pair ramps duty at each turn-on.
// - Overload trip from i-squared-t against rating and delay.
// - Instant threshold is rating times 5 to 20.
// - Short-time threshold is rating times 1.5 to 6.0.
// - Overload delay is 5, 10 or 20 s.
// - Per-breaker selector picks its controlling signal.
// - Dimming from one of eight counters or a direct level.
// - Live voltage and current per breaker.
// - Flags show tripped and the tripping protection.
// - Flags for thermal, shed, hardware fault, ground and supply shorts.
// - Overcurrent flag set on overload trip.
// - Open-load flag when on and under 1.0 A.
// - Locked breaker flags lock and ignores network commands.
// - Sixteen network inputs drive their selected breakers.
// - Instance number is held for the status report.
`timescale 1ns/1ps
`default_nettype none
module dc_breaker_channel_control #(
   parameter int TICK_CYCLES = dcb_pkg::TICK_CYCLES,
   parameter int RAMP_CYCLES = dcb_pkg::RAMP_CYCLES
) (
   input  wire logic                             clk,
   input  wire logic                             resetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [11:0]                      paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic [dcb_pkg::NUM_CH-1:0][11:0] current_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0][11:0] voltage_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0]       thermal_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0]       shed_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0]       hw_fault_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0]       short_gnd_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0]       short_bat_in,
   input  wire logic [dcb_pkg::NUM_CH-1:0]       retained_state_in,
   output logic      [dcb_pkg::NUM_CH-1:0]       drive_high,
   output logic      [dcb_pkg::NUM_CH-1:0]       drive_low,
   output logic      [dcb_pkg::NUM_CH-1:0]       state_hold,
   output logic      [7:0]                       instance_number
);
   localparam int N = dcb_pkg::NUM_CH;

   logic [N-1:0][11:0] cur_m, cur_s, volt_m, volt_s;
   logic [6*N-1:0]     pin_m, pin_s;
   logic [N-1:0]       th_s, shed_s, hwf_s, sgnd_s, sbat_s, ret_s;

   logic [31:0] cfg     [N];
   logic [11:0] rating  [N];
   logic [15:0] duty    [N];
   logic [11:0] flags   [N];
   logic [7:0]  eff_duty[N];
   logic [N-1:0] on, trip, locked;

   logic [15:0] netin, netin_prev;
   logic [7:0]  cnt_duty [dcb_pkg::NUM_CNT];

   logic [27:0] tick_cnt;
   logic        tick;
   logic [6:0]  pwm_div;
   logic [7:0]  pwm_cnt;
   logic [1:0]  init_cnt;
   logic        start;

   logic        acc_netin, acc_inst, acc_cnt, acc_chan, acc_meas, hit;
   logic [31:0] rdata;
   logic        wr_en;

   // Pins come from outside the clock domain
   always_ff @(posedge clk) begin
      cur_m  <= current_in;
      cur_s  <= cur_m;
      volt_m <= voltage_in;
      volt_s <= volt_m;
      pin_m  <= {retained_state_in, short_bat_in, short_gnd_in, hw_fault_in, shed_in, thermal_in};
      pin_s  <= pin_m;
   end
   assign {ret_s, sbat_s, sgnd_s, hwf_s, shed_s, th_s} = pin_s;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tick_cnt <= 28'h0;
         tick     <= 1'b0;
      end else if (tick_cnt == 28'(TICK_CYCLES - 1)) begin
         tick_cnt <= 28'h0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 28'h1;
         tick     <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pwm_div <= 7'h0;
         pwm_cnt <= 8'h0;
      end else if (pwm_div == dcb_pkg::PWM_DIV) begin
         pwm_div <= 7'h0;
         pwm_cnt <= pwm_cnt + 8'h1;
      end else begin
         pwm_div <= pwm_div + 7'h1;
      end
   end

   // Defaults wait until the retained-state pins are synchronised
   always_ff @(posedge clk) begin
      if (!resetn) begin
         init_cnt <= 2'h0;
      end else if (init_cnt != 2'h3) begin
         init_cnt <= init_cnt + 2'h1;
      end
   end
   assign start = (init_cnt == dcb_pkg::INIT_APPLY);

   always_comb begin
      acc_netin = 1'b0;
      acc_inst  = 1'b0;
      acc_cnt   = 1'b0;
      acc_chan  = 1'b0;
      acc_meas  = 1'b0;
      rdata     = 32'h0;
      if (paddr[1:0] != 2'h0) begin
         acc_netin = 1'b0;
      end else if (paddr == dcb_pkg::ADDR_NETIN) begin
         acc_netin = 1'b1;
         rdata     = {16'h0, netin};
      end else if (paddr == dcb_pkg::ADDR_INSTANCE) begin
         acc_inst = 1'b1;
         rdata    = {24'h0, instance_number};
      end else if (paddr[11:5] == dcb_pkg::ADDR_COUNTER[11:5]) begin
         acc_cnt = 1'b1;
         rdata   = {24'h0, cnt_duty[paddr[4:2]]};
      end else if (paddr[11:8] == dcb_pkg::ADDR_CHAN[11:8]) begin
         acc_chan = 1'b1;
         if (paddr[3:2] == dcb_pkg::CH_CFG) begin
            rdata = cfg[paddr[7:4]];
         end else if (paddr[3:2] == dcb_pkg::CH_RATING) begin
            rdata = {20'h0, rating[paddr[7:4]]};
         end else if (paddr[3:2] == dcb_pkg::CH_DUTY) begin
            rdata = {16'h0, duty[paddr[7:4]]};
         end else begin
            rdata = {14'h0, trip[paddr[7:4]], on[paddr[7:4]], 4'h0, flags[paddr[7:4]]};
         end
      end else if (paddr[11:6] == dcb_pkg::ADDR_MEAS[11:6]) begin
         acc_meas = 1'b1;
         rdata    = {4'h0, volt_s[paddr[5:2]], 4'h0, cur_s[paddr[5:2]]};
      end
   end
   assign hit   = acc_netin | acc_inst | acc_cnt | acc_chan | acc_meas;
   assign wr_en = psel & penable & pready & pwrite & hit;

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~hit;
         prdata  <= pwrite ? 32'h0 : rdata;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         netin           <= 16'h0;
         netin_prev      <= 16'h0;
         instance_number <= dcb_pkg::INST_RESET;
      end else begin
         netin_prev <= netin;
         if (wr_en && acc_netin) begin
            netin <= pwdata[15:0];
         end
         if (wr_en && acc_inst) begin
            instance_number <= pwdata[7:0];
         end
      end
   end

   generate
      for (genvar k = 0; k < dcb_pkg::NUM_CNT; k++) begin : g_cnt
         always_ff @(posedge clk) begin
            if (!resetn) begin
               cnt_duty[k] <= 8'h0;
            end else if (wr_en && acc_cnt && paddr[4:2] == 3'(k)) begin
               cnt_duty[k] <= pwdata[7:0];
            end
         end
      end

      for (genvar c = 0; c < N; c++) begin : g_ch
         localparam int A = (c == 1 || c == 11) ? c - 1 : c;
         localparam int B = (c == 0 || c == 10) ? c + 1 : c;
         localparam bit PAIR = (c == 0 || c == 1 || c == 10 || c == 11);

         logic        wsel;
         logic [2:0]  btype;
         logic [3:0]  insel, cntsel;
         logic        cmd_on, cmd_off, acc_on, acc_off;
         logic [16:0] inst_thr;
         logic [17:0] cur10, short_thr;
         logic [23:0] i2, r2;
         logic [39:0] limit, i2t_acc;
         logic [12:0] lim_ticks;
         logic [7:0]  short_cnt;
         logic        over, inst_trip, short_trip, long_trip, ovc;
         logic        fault_trip, ramped, bridge, run, pwm_on;
         logic [7:0]  ramp_duty;
         logic [24:0] ramp_acc, ramp_step;
         logic [11:0] set_flags;

         assign wsel   = wr_en && acc_chan && paddr[7:4] == 4'(c);
         assign btype  = cfg[c][dcb_pkg::F_TYPE +: 3];
         assign insel  = cfg[c][dcb_pkg::F_INSEL +: 4];
         assign cntsel = cfg[c][dcb_pkg::F_CNTSEL +: 4];

         always_ff @(posedge clk) begin
            if (!resetn) begin
               cfg[c]    <= dcb_pkg::CFG_RESET | (32'(c) << dcb_pkg::F_INSEL);
               rating[c] <= dcb_pkg::RATING_RESET;
               duty[c]   <= dcb_pkg::DUTY_RESET;
            end else if (wsel && paddr[3:2] == dcb_pkg::CH_CFG) begin
               cfg[c] <= pwdata;
            end else if (wsel && paddr[3:2] == dcb_pkg::CH_RATING) begin
               rating[c] <= pwdata[11:0];
            end else if (wsel && paddr[3:2] == dcb_pkg::CH_DUTY) begin
               duty[c] <= pwdata[15:0];
            end
         end

         always_ff @(posedge clk) begin
            if (!resetn) begin
               locked[c] <= 1'b0;
            end else if (start) begin
               locked[c] <= cfg[c][dcb_pkg::F_DEFLOCK];
            end else if (wsel && paddr[3:2] == dcb_pkg::CH_CFG) begin
               locked[c] <= pwdata[dcb_pkg::F_LOCK];
            end
         end

         // Only edges of the selected network input switch the breaker
         assign cmd_on  = netin[insel] & ~netin_prev[insel];
         assign cmd_off = ~netin[insel] & netin_prev[insel];
         assign acc_on  = cmd_on & ~locked[c];
         assign acc_off = cmd_off & ~locked[c];

         assign inst_thr  = {5'h0, rating[c]} * {12'h0, cfg[c][dcb_pkg::F_INST +: 5]};
         assign cur10     = {6'h0, cur_s[c]} * 18'h0000A;
         assign short_thr = {6'h0, rating[c]} * {12'h0, cfg[c][dcb_pkg::F_SHORT +: 6]};
         assign i2        = {12'h0, cur_s[c]} * {12'h0, cur_s[c]};
         assign r2        = {12'h0, rating[c]} * {12'h0, rating[c]};
         assign over      = cur_s[c] > rating[c];

         always_comb begin
            if (cfg[c][dcb_pkg::F_DELAY +: 2] == dcb_pkg::DLY_FAST) begin
               lim_ticks = dcb_pkg::LIM_FAST;
            end else if (cfg[c][dcb_pkg::F_DELAY +: 2] == dcb_pkg::DLY_MEDIUM) begin
               lim_ticks = dcb_pkg::LIM_MEDIUM;
            end else begin
               lim_ticks = dcb_pkg::LIM_SLOW;
            end
         end
         assign limit = {16'h0, r2} * {27'h0, lim_ticks};

         // Excess heat cools by one rating-square per tick at or below rating
         always_ff @(posedge clk) begin
            if (!resetn || !on[c]) begin
               i2t_acc <= 40'h0;
            end else if (tick && over) begin
               i2t_acc <= i2t_acc + {16'h0, i2 - r2};
            end else if (tick) begin
               i2t_acc <= (i2t_acc > {16'h0, r2}) ? i2t_acc - {16'h0, r2} : 40'h0;
            end
         end

         always_ff @(posedge clk) begin
            if (!resetn || !on[c] || cur10 <= short_thr) begin
               short_cnt <= 8'h0;
            end else if (tick && short_cnt != 8'hFF) begin
               short_cnt <= short_cnt + 8'h1;
            end
         end

         assign inst_trip  = on[c] && {5'h0, cur_s[c]} > inst_thr;
         assign short_trip = on[c] && short_cnt >= dcb_pkg::SHORT_DELAY_TICKS;
         assign long_trip  = on[c] && i2t_acc >= limit && r2 != 24'h0;
         assign ovc        = inst_trip | short_trip | long_trip;
         assign fault_trip = on[c] & (th_s[c] | hwf_s[c] | sgnd_s[c] | sbat_s[c]);

         always_comb begin
            set_flags                     = 12'h0;
            set_flags[dcb_pkg::S_TRIPPED] = ovc | fault_trip;
            set_flags[dcb_pkg::S_INST]    = inst_trip;
            set_flags[dcb_pkg::S_SHORT]   = short_trip;
            set_flags[dcb_pkg::S_LONG]    = long_trip;
            set_flags[dcb_pkg::S_THERM]   = on[c] & th_s[c];
            set_flags[dcb_pkg::S_SHED]    = on[c] & shed_s[c];
            set_flags[dcb_pkg::S_HWF]     = on[c] & hwf_s[c];
            set_flags[dcb_pkg::S_SGND]    = on[c] & sgnd_s[c];
            set_flags[dcb_pkg::S_SBAT]    = on[c] & sbat_s[c];
            set_flags[dcb_pkg::S_OVC]     = ovc;
         end

         // A cause arriving with the clearing on command wins
         always_ff @(posedge clk) begin
            if (!resetn) begin
               flags[c] <= 12'h0;
            end else begin
               flags[c]                     <= ((acc_on ? 12'h0 : flags[c]) | set_flags);
               flags[c][dcb_pkg::S_OPEN]    <= on[c] && cur_s[c] < dcb_pkg::OPEN_LOAD_COUNTS;
               flags[c][dcb_pkg::S_LOCKED]  <= locked[c];
            end
         end

         always_ff @(posedge clk) begin
            if (!resetn) begin
               on[c]   <= 1'b0;
               trip[c] <= 1'b0;
            end else if (start) begin
               on[c]   <= cfg[c][dcb_pkg::F_DEFSTATE +: 2] == dcb_pkg::DEF_ON ||
                          (cfg[c][dcb_pkg::F_DEFSTATE +: 2] == dcb_pkg::DEF_LAST && ret_s[c]);
               trip[c] <= 1'b0;
            end else if (ovc || fault_trip) begin
               on[c]   <= 1'b0;
               trip[c] <= 1'b1;
            end else if (on[c] && shed_s[c]) begin
               on[c] <= 1'b0;
            end else if (acc_on) begin
               on[c]   <= 1'b1;
               trip[c] <= 1'b0;
            end else if (acc_off) begin
               on[c] <= 1'b0;
            end
         end

         assign ramped    = btype == dcb_pkg::TYPE_RAMPED_SWITCH || btype == dcb_pkg::TYPE_RAMPED_BRIDGE;
         assign ramp_step = {17'h0, 8'hFF - duty[c][15:8]};

         // Held at the start duty while off, so turn-on never flashes full power
         always_ff @(posedge clk) begin
            if (!resetn || !on[c]) begin
               ramp_duty <= duty[c][15:8];
               ramp_acc  <= 25'h0;
            end else if (ramp_duty != 8'hFF) begin
               if (ramp_acc + ramp_step >= 25'(RAMP_CYCLES)) begin
                  ramp_acc  <= ramp_acc + ramp_step - 25'(RAMP_CYCLES);
                  ramp_duty <= ramp_duty + 8'h1;
               end else begin
                  ramp_acc <= ramp_acc + ramp_step;
               end
            end
         end

         always_comb begin
            if (btype == dcb_pkg::TYPE_DIMMED) begin
               eff_duty[c] = (cntsel == 4'h0) ? duty[c][7:0] : cnt_duty[3'(cntsel - 4'h1)];
            end else if (ramped) begin
               eff_duty[c] = ramp_duty;
            end else begin
               eff_duty[c] = 8'hFF;
            end
         end

         assign bridge = PAIR && cfg[A][dcb_pkg::F_TYPE +: 3] == cfg[B][dcb_pkg::F_TYPE +: 3] &&
                         (cfg[A][dcb_pkg::F_TYPE +: 3] == dcb_pkg::TYPE_BRIDGE ||
                          cfg[A][dcb_pkg::F_TYPE +: 3] == dcb_pkg::TYPE_RAMPED_BRIDGE);
         // In a bridge the first breaker of the pair holds state, duty and direction
         assign run    = bridge ? (on[A] & ~trip[B]) : on[c];
         assign pwm_on = eff_duty[A] == 8'hFF || pwm_cnt < eff_duty[bridge ? A : c];

         always_ff @(posedge clk) begin
            if (!resetn) begin
               drive_high[c] <= 1'b0;
               drive_low[c]  <= 1'b0;
               state_hold[c] <= 1'b0;
            end else begin
               state_hold[c] <= on[c];
               if (bridge) begin
                  drive_high[c] <= run & pwm_on & (cfg[A][dcb_pkg::F_DIR] == (c != A));
                  drive_low[c]  <= run & (cfg[A][dcb_pkg::F_DIR] != (c != A));
               end else begin
                  drive_high[c] <= run & (eff_duty[c] == 8'hFF || pwm_cnt < eff_duty[c]);
                  drive_low[c]  <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* File: hw/dcb_pkg.sv */
package dcb_pkg;
   localparam int NUM_CH  = 16;
   localparam int NUM_NET = 16;
   localparam int NUM_CNT = 8;
   localparam int ADC_W   = 12;

   localparam int CLK_HZ         = 25_000_000;
   localparam int TICK_MS        = 10;
   localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
   localparam int RAMP_MS        = 1000;
   localparam int RAMP_CYCLES    = CLK_HZ / 1000 * RAMP_MS;
   localparam int SHORT_DELAY_MS = 100;
   localparam logic [7:0] SHORT_DELAY_TICKS = 8'(SHORT_DELAY_MS / TICK_MS);
   localparam logic [6:0] PWM_DIV = 7'h61;
   localparam logic [1:0] INIT_APPLY = 2'h2;

   // Overload trips at twice the rating after the delay: excess I^2 is 3 R^2
   localparam int FAST_S   = 5;
   localparam int MEDIUM_S = 10;
   localparam int SLOW_S   = 20;
   localparam logic [12:0] LIM_FAST   = 13'(3 * FAST_S * 1000 / TICK_MS);
   localparam logic [12:0] LIM_MEDIUM = 13'(3 * MEDIUM_S * 1000 / TICK_MS);
   localparam logic [12:0] LIM_SLOW   = 13'(3 * SLOW_S * 1000 / TICK_MS);

   // Current readings are 10 mA per count
   localparam logic [11:0] OPEN_LOAD_COUNTS = 12'h064;

   localparam logic [11:0] ADDR_NETIN    = 12'h000;
   localparam logic [11:0] ADDR_INSTANCE = 12'h004;
   localparam logic [11:0] ADDR_COUNTER  = 12'h020;
   localparam logic [11:0] ADDR_CHAN     = 12'h100;
   localparam logic [11:0] ADDR_MEAS     = 12'h200;
   localparam logic [1:0]  CH_CFG        = 2'h0;
   localparam logic [1:0]  CH_RATING     = 2'h1;
   localparam logic [1:0]  CH_DUTY       = 2'h2;
   localparam logic [1:0]  CH_STATUS     = 2'h3;

   localparam int F_DEFSTATE = 0;
   localparam int F_DEFLOCK  = 2;
   localparam int F_TYPE     = 3;
   localparam int F_DELAY    = 6;
   localparam int F_INSEL    = 8;
   localparam int F_CNTSEL   = 12;
   localparam int F_INST     = 16;
   localparam int F_SHORT    = 21;
   localparam int F_LOCK     = 27;
   localparam int F_DIR      = 28;

   localparam int S_TRIPPED = 0;
   localparam int S_INST    = 1;
   localparam int S_SHORT   = 2;
   localparam int S_LONG    = 3;
   localparam int S_THERM   = 4;
   localparam int S_SHED    = 5;
   localparam int S_HWF     = 6;
   localparam int S_SGND    = 7;
   localparam int S_SBAT    = 8;
   localparam int S_OVC     = 9;
   localparam int S_OPEN    = 10;
   localparam int S_LOCKED  = 11;

   localparam logic [31:0] CFG_RESET    = 32'h078A0040;
   localparam logic [11:0] RATING_RESET = 12'h0C8;
   localparam logic [15:0] DUTY_RESET   = 16'h40FF;
   localparam logic [7:0]  INST_RESET   = 8'h00;

   localparam logic [2:0] TYPE_DC             = 3'h0;
   localparam logic [2:0] TYPE_DIMMED         = 3'h1;
   localparam logic [2:0] TYPE_RAMPED_SWITCH  = 3'h2;
   localparam logic [2:0] TYPE_BRIDGE         = 3'h3;
   localparam logic [2:0] TYPE_RAMPED_BRIDGE  = 3'h4;

   localparam logic [1:0] ST_OFF  = 2'h0;
   localparam logic [1:0] ST_ON   = 2'h1;
   localparam logic [1:0] ST_TRIP = 2'h2;

   localparam logic [1:0] DEF_OFF  = 2'h0;
   localparam logic [1:0] DEF_ON   = 2'h1;
   localparam logic [1:0] DEF_LAST = 2'h2;

   localparam logic [1:0] DLY_FAST   = 2'h0;
   localparam logic [1:0] DLY_MEDIUM = 2'h1;
endpackage

/* File: verification/dcb_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module dcb_checker (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] drive_high,
   input wire logic [15:0] drive_low,
   input wire logic [7:0]  instance_number
);
   logic [7:0] inst_w;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_inst; psel && penable && pready && pwrite && paddr == dcb_pkg::ADDR_INSTANCE; endsequence
   always_ff @(posedge clk) begin
      if (psel && penable && pready && pwrite && paddr == dcb_pkg::ADDR_INSTANCE) begin
         inst_w <= pwdata[7:0];
      end
   end
   a_ready_one: assert property (s_wait |=> pready)
      else $error("late ready");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("stray ready");
   a_err_misalign: assert property (s_wait ##0 paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misalign accepted");
   a_inst_write: assert property (s_inst |=> ##[0:1] instance_number == inst_w)
      else $error("instance stale");
   a_legs_apart: assert property ((drive_high & drive_low) == 16'h0000)
      else $error("both legs driven");
   a_low_pairs: assert property ((drive_low & 16'hF3FC) == 16'h0000)
      else $error("stray low leg");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> drive_high == 16'h0000 && !pready)
      else $error("active in reset");
endmodule
bind dc_breaker_channel_control dcb_checker u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .drive_high, .drive_low, .instance_number);
`default_nettype wire

/* File: verification/dcb_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcb_load_model (
   input  wire logic [15:0]       drive_high,
   input  wire logic [15:0]       drive_low,
   input  wire logic [15:0][11:0] load,
   input  wire logic [11:0]       supply,
   output logic      [15:0][11:0] current_in,
   output logic      [15:0][11:0] voltage_in
);
   // A load conducts only while a leg drives it; off terminals read zero
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         current_in[i] = (drive_high[i] | drive_low[i]) ? load[i] : 12'h000;
         voltage_in[i] = (drive_high[i] | drive_low[i]) ? supply : 12'h000;
      end
   end
endmodule
`default_nettype wire

/* File: verification/dc_breaker_channel_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dc_breaker_channel_control_tb_top;
   logic              clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0]       paddr = 0, supply;
   logic [31:0]       pwdata = 0, prdata, rd, v, seed = 60655;
   logic [15:0]       drive_high, drive_low, state_hold, ret, netv = 0;
   logic [4:0][15:0]  flt = 0;
   logic [15:0][11:0] cur, volt, load;
   logic [7:0]        inst;
   logic [9:0]        m_fl [16] = '{default: 0};
   bit                m_on [16], m_trip [16], m_lock [16];
   int                bad_count = 0, n_tests = 0, cyc = 0, hi;
   dc_breaker_channel_control #(.TICK_CYCLES(20), .RAMP_CYCLES(1000)) dut (.clk, .resetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .current_in(cur),
      .voltage_in(volt), .thermal_in(flt[0]), .shed_in(flt[1]), .hw_fault_in(flt[2]),
      .short_gnd_in(flt[3]), .short_bat_in(flt[4]), .retained_state_in(ret), .drive_high,
      .drive_low, .state_hold, .instance_number(inst));
   dcb_load_model partner (.drive_high, .drive_low, .load, .supply, .current_in(cur), .voltage_in(volt));
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         end_sim();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] ca(input int c, input int r);
      return dcb_pkg::ADDR_CHAN + 12'(16 * c + 4 * r);
   endfunction
   function automatic logic [31:0] st(input int c);
      return {14'h0, m_trip[c], m_on[c], 4'h0, m_lock[c], m_on[c] && load[c] < dcb_pkg::OPEN_LOAD_COUNTS, m_fl[c]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(nm, rd, exp);
   endtask
   task automatic cfg(input int c, input logic [31:0] d);
      apb(1'b1, ca(c, dcb_pkg::CH_CFG), dcb_pkg::CFG_RESET | d);
      repeat (8) @(posedge clk);
   endtask
   task automatic sc(input int c);
      apb(1'b0, ca(c, dcb_pkg::CH_STATUS), '0);
      chk("status", rd, st(c));
      chk("hold", 32'(state_hold[c]), 32'(m_on[c]));
   endtask
   task automatic tr(input int c, input logic [9:0] f);
      m_on[c] = 0;
      m_trip[c] = f[0];
      m_fl[c] = f;
   endtask
   task automatic hc();
      hi = 0;
      repeat (600) begin
         @(posedge clk);
         hi += drive_high[14];
      end
   endtask
   task automatic net(input int b, input bit on);
      netv[b] = on;
      apb(1'b1, dcb_pkg::ADDR_NETIN, {16'h0000, netv});
      if (!m_lock[b]) begin
         m_trip[b] = on ? 1'b0 : m_trip[b];
         m_fl[b] = on ? 10'h000 : m_fl[b];
         m_on[b] = on;
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      ret = 16'(xs());
      supply = 12'(xs());
      load = {16{12'h096}};
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      rc("config", ca(7, dcb_pkg::CH_CFG), dcb_pkg::CFG_RESET | 32'h0700);
      rc("rating", ca(7, dcb_pkg::CH_RATING), 32'(dcb_pkg::RATING_RESET));
      sc(7);
      v = xs();
      apb(1'b1, dcb_pkg::ADDR_INSTANCE, v);
      rc("instance", dcb_pkg::ADDR_INSTANCE, v & 32'hFF);
      chk("instance port", 32'(inst), v & 32'hFF);
      rc("unmapped", 12'h3FC, 0);
      chk("unmapped err", 32'(err), 1);
      apb(1'b0, 12'h102, '0);
      chk("misaligned err", 32'(err), 1);
      net(3, 1);
      sc(3);
      rc("meas", dcb_pkg::ADDR_MEAS + 12'h00C, {4'h0, supply, 4'h0, load[3]});
      load[3] <= 12'h032;
      repeat (8) @(posedge clk);
      sc(3);
      cfg(4, 32'h0800_0400);
      m_lock[4] = 1;
      net(4, 1);
      sc(4);
      cfg(4, 32'h0400);
      m_lock[4] = 0;
      net(4, 0);
      net(4, 1);
      sc(4);
      $display("control done");
      net(5, 1);
      load[5] <= 12'h7D0;
      repeat (8) @(posedge clk);
      sc(5);
      load[5] <= 12'h7D1;
      repeat (8) @(posedge clk);
      tr(5, 10'h203);
      sc(5);
      load[5] <= 12'h096;
      net(5, 0);
      sc(5);
      net(5, 1);
      sc(5);
      for (int k = 0; k < 5; k++) begin
         net(6 + k, 1);
         flt[k][6 + k] <= 1'b1;
         repeat (8) @(posedge clk);
         tr(6 + k, 10'(1 << (dcb_pkg::S_THERM + k)) | 10'(k != 1));
         sc(6 + k);
         flt[k][6 + k] <= 1'b0;
      end
      net(12, 1);
      net(13, 1);
      load[12] <= 12'h190;
      load[13] <= 12'h514;
      repeat (150) @(posedge clk);
      chk("short hold", 32'(drive_high[13]), 1);
      repeat (150) @(posedge clk);
      tr(13, 10'h205);
      sc(13);
      repeat (18700) @(posedge clk);
      chk("overload hold", 32'(drive_high[12]), 1);
      repeat (2500) @(posedge clk);
      tr(12, 10'h209);
      sc(12);
      chk("overcurrent", 32'(rd[9]), 1);
      $display("protection done");
      cfg(14, 32'h0E08);
      apb(1'b1, ca(14, dcb_pkg::CH_DUTY), 32'h4000);
      net(14, 1);
      hc();
      chk("dim zero", hi, 0);
      apb(1'b1, dcb_pkg::ADDR_COUNTER + 12'h004, 32'hFF);
      cfg(14, 32'h2E08);
      hc();
      chk("dim full", hi, 600);
      cfg(15, 32'h0F10);
      net(15, 1);
      repeat (1100) @(posedge clk);
      chk("ramp full", 32'(drive_high[15]), 1);
      cfg(0, 32'h18);
      cfg(1, 32'h118);
      net(0, 1);
      chk("bridge fwd", {drive_high[1:0], drive_low[1:0]}, 4'b0110);
      cfg(0, 32'h1000_0018);
      chk("bridge rev", {drive_high[1:0], drive_low[1:0]}, 4'b1001);
      $display("modes done");
      end_sim();
   end
endmodule
`default_nettype wire
